// ### pal_macrocell_regs.svh
// offsets, field positions, reset values and array sizes for the
// programmable output macrocell array; included by package and module
`ifndef PAL_MACROCELL_REGS_SVH
`define PAL_MACROCELL_REGS_SVH

// array shape
`define PAL_NUM_IN      12
`define PAL_NUM_MC      10
`define PAL_NUM_ARR     22
`define PAL_NUM_COL     44
`define PAL_NUM_SUM     120
`define PAL_NUM_PT      132
`define PAL_PT_OE       120
`define PAL_PT_SET      130
`define PAL_PT_CLR      131
`define PAL_PT_MIN      8
`define PAL_PT_STEP     2
`define PAL_PT_MAX      16
`define PAL_HI_W        12

// bus geometry
`define PAL_ADDR_W      12
`define PAL_DATA_W      32

// register byte offsets
`define PAL_OFF_MODE    12'h000
`define PAL_OFF_POL     12'h004
`define PAL_OFF_SEC     12'h008
`define PAL_OFF_PRELOAD 12'h00C
`define PAL_OFF_STATUS  12'h010
`define PAL_OFF_TERM    12'h400
`define PAL_OFF_TERM_END 12'h820

// status field positions
`define PAL_STAT_PIN_LSB 0
`define PAL_STAT_OE_LSB  16

// reset values
`define PAL_RST_MODE    10'h000
`define PAL_RST_POL     10'h000
`define PAL_RST_Q       10'h000

// bus responses
`define PAL_RESP_OKAY   2'h0
`define PAL_RESP_DECERR 2'h3

`endif

// ### pal_pkg.sv
// types shared by the macrocell array and whatever instantiates it
// assumes the constants header is on the include path
package pal_pkg;
	`include "pal_macrocell_regs.svh"

	typedef logic [`PAL_NUM_MC-1:0]  pal_mc_t;  // one bit per macrocell
	typedef logic [`PAL_NUM_COL-1:0] pal_row_t; // one product-term row

	// master-driven side of the axi4-lite register port
	typedef struct packed {
		logic                   awvalid;
		logic [`PAL_ADDR_W-1:0] awaddr;
		logic                   wvalid;
		logic [`PAL_DATA_W-1:0] wdata;
		logic [3:0]             wstrb;
		logic                   bready;
		logic                   arvalid;
		logic [`PAL_ADDR_W-1:0] araddr;
		logic                   rready;
	} pal_axi_req_t;

	// slave-driven side of the axi4-lite register port
	typedef struct packed {
		logic                   awready;
		logic                   wready;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   arready;
		logic                   rvalid;
		logic [`PAL_DATA_W-1:0] rdata;
		logic [1:0]             rresp;
	} pal_axi_rsp_t;
endpackage

// ### pal_macrocell_array.sv
// programmable sum-of-products array with ten output macrocells
// assumes SYS_CLK at 100 MHz, pins asynchronous to it, and fuses
// loaded over axi4-lite before the outputs are trusted
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`include "pal_macrocell_regs.svh"

module pal_macrocell_array (
	input  wire logic                   SYS_CLK,
	input  wire logic                   NRST,
	input  wire logic [`PAL_NUM_IN-1:0] DIN,
	input  wire pal_pkg::pal_mc_t       IO_IN,
	output logic      [`PAL_NUM_MC-1:0] IO_OUT,
	output logic      [`PAL_NUM_MC-1:0] IO_OE,
	input  wire pal_pkg::pal_axi_req_t  AXI_REQ,
	output pal_pkg::pal_axi_rsp_t       AXI_RSP
);
	import pal_pkg::*;

	// assertions below all run on the system clock, off during reset
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);

	// product terms allotted to macrocell n, widest in the middle
	function automatic int pt_cnt(input int n);
		int d;
		d = (n < `PAL_NUM_MC - 1 - n) ? n : `PAL_NUM_MC - 1 - n;
		return `PAL_PT_MIN + `PAL_PT_STEP * d;
	endfunction

	// first product term row of macrocell n
	function automatic int pt_base(input int n);
		int s;
		s = 0;
		for (int i = 0; i < n; i++) begin
			s = s + pt_cnt(i);
		end
		return s;
	endfunction

	// address falls inside the product-term window
	function automatic logic term_hit(input logic [`PAL_ADDR_W-1:0] a);
		return (a >= `PAL_OFF_TERM) && (a < `PAL_OFF_TERM_END)
			&& (a[1:0] == 2'h0);
	endfunction

	// row number of a product-term address
	function automatic logic [7:0] term_idx(input logic [`PAL_ADDR_W-1:0] a);
		logic [`PAL_ADDR_W-1:0] off;
		off = a - `PAL_OFF_TERM;
		return off[10:3];
	endfunction

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] strb_merge(
		input logic [31:0] old_w,
		input logic [31:0] new_w,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old_w;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = new_w[8*b +: 8];
			end
		end
		return r;
	endfunction

	// pin synchronisers, two stages each
	logic [`PAL_NUM_IN-1:0] din_m_ff;   // first stage, dedicated inputs
	logic [`PAL_NUM_IN-1:0] din_s_ff;   // usable dedicated inputs
	pal_mc_t                pin_m_ff;   // first stage, i/o pins
	pal_mc_t                pin_s_ff;   // usable i/o pin levels

	// fuse storage and macrocell state
	pal_row_t               fuse_ff [`PAL_NUM_PT]; // 1 = blown, open
	pal_mc_t                mode_ff;    // feedback_mode_fuse per cell
	pal_mc_t                pol_ff;     // polarity_fuse per cell
	logic                   sec_ff;     // security fuse
	pal_mc_t                q_ff;       // output registers

	// array evaluation
	logic [`PAL_NUM_ARR-1:0] arr_in;    // inputs plus feedback
	pal_row_t               lit;        // true and complement columns
	logic [`PAL_NUM_PT-1:0] pt;         // every product term
	pal_mc_t                sum;        // OR of each cell's terms
	logic                   set_pt;     // shared synchronous set
	logic                   clr_pt;     // shared asynchronous reset
	logic                   clr_async;  // power-up or reset term

	// bus slave state
	logic                   aw_hold_ff; // write address captured
	logic [`PAL_ADDR_W-1:0] aw_addr_ff;
	logic                   w_hold_ff;  // write data captured
	logic [31:0]            w_data_ff;
	logic [3:0]             w_strb_ff;
	logic                   bvalid_ff;
	logic [1:0]             bresp_ff;
	logic                   rvalid_ff;
	logic [31:0]            rdata_ff;
	logic [1:0]             rresp_ff;
	logic                   do_wr;      // both halves of a write held
	logic                   wr_ok;      // write address is mapped
	logic                   pre_we;     // preload write this cycle
	logic [31:0]            nxt_rdata;
	logic [1:0]             nxt_rresp;
	logic [31:0]            q_mrg;      // preload word merged into q
	logic [31:0]            mode_mrg;   // mode word after byte merge
	logic [31:0]            pol_mrg;    // polarity word after byte merge
	pal_row_t               row_sel;    // fuse row addressed by the write
	logic [31:0]            row_lo_mrg; // low fuse word after merge
	logic [31:0]            row_hi_mrg; // high fuse word after merge

	// two flops before any array logic sees a pin
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			din_m_ff <= '0;
			din_s_ff <= '0;
			pin_m_ff <= '0;
			pin_s_ff <= '0;
		end else begin
			din_m_ff <= DIN;
			din_s_ff <= din_m_ff;
			pin_m_ff <= IO_IN;
			pin_s_ff <= pin_m_ff;
		end
	end

	// feedback: register state or pin level per cell
	always_comb begin
		for (int n = 0; n < `PAL_NUM_MC; n++) begin
			arr_in[`PAL_NUM_IN + n] = mode_ff[n] ? pin_s_ff[n] : q_ff[n];
		end
		arr_in[`PAL_NUM_IN-1:0] = din_s_ff;
		lit = {~arr_in, arr_in};
	end

	// AND plane: an intact fuse ties its column into the term, so a
	// row with every fuse intact is always false (x and not x)
	always_comb begin
		for (int t = 0; t < `PAL_NUM_PT; t++) begin
			pt[t] = &(lit | fuse_ff[t]);
		end
	end

	// OR plane with the uneven term split
	always_comb begin
		for (int n = 0; n < `PAL_NUM_MC; n++) begin
			sum[n] = 1'b0;
			for (int k = 0; k < `PAL_PT_MAX; k++) begin
				if (k < pt_cnt(n)) begin
					sum[n] = sum[n] | pt[pt_base(n) + k];
				end
			end
		end
	end

	// one set and one reset term feed all ten registers
	assign set_pt    = pt[`PAL_PT_SET];
	assign clr_pt    = pt[`PAL_PT_CLR];
	// reset term is decoded logic; a glitch on it clears registers,
	// which matches the part but wants clean fuse patterns
	assign clr_async = !NRST || clr_pt;

	// output registers: clear beats preload beats set beats data
	always_ff @(posedge SYS_CLK or posedge clr_async) begin
		if (clr_async) begin
			q_ff <= `PAL_RST_Q;
		end else if (pre_we) begin
			q_ff <= q_mrg[`PAL_NUM_MC-1:0];
		end else if (set_pt) begin
			q_ff <= '1;
		end else begin
			q_ff <= sum;
		end
	end

	// pin drivers; combinational cells bypass the register entirely
	always_comb begin
		for (int n = 0; n < `PAL_NUM_MC; n++) begin
			if (mode_ff[n]) begin
				IO_OUT[n] = pol_ff[n] ? sum[n] : ~sum[n];
			end else begin
				IO_OUT[n] = pol_ff[n] ? q_ff[n] : ~q_ff[n];
			end
			IO_OE[n] = pt[`PAL_PT_OE + n];
		end
	end

	// byte merges of the held write; a function result cannot be
	// bit-selected portably, so each merge gets its own word
	assign q_mrg    = strb_merge({22'h0, q_ff}, w_data_ff, w_strb_ff);
	assign mode_mrg = strb_merge({22'h0, mode_ff}, w_data_ff, w_strb_ff);
	assign pol_mrg  = strb_merge({22'h0, pol_ff}, w_data_ff, w_strb_ff);
	assign row_sel  = fuse_ff[term_idx(aw_addr_ff)];
	assign row_lo_mrg = strb_merge(row_sel[31:0], w_data_ff, w_strb_ff);
	assign row_hi_mrg = strb_merge({20'h0, row_sel[`PAL_NUM_COL-1:32]},
		w_data_ff, w_strb_ff);

	// write decode
	assign do_wr  = aw_hold_ff && w_hold_ff && !bvalid_ff;
	assign pre_we = do_wr && (aw_addr_ff == `PAL_OFF_PRELOAD);
	always_comb begin
		if (aw_addr_ff == `PAL_OFF_MODE) begin
			wr_ok = 1'b1;
		end else if (aw_addr_ff == `PAL_OFF_POL) begin
			wr_ok = 1'b1;
		end else if (aw_addr_ff == `PAL_OFF_SEC) begin
			wr_ok = 1'b1;
		end else if (aw_addr_ff == `PAL_OFF_PRELOAD) begin
			wr_ok = 1'b1;
		end else if (aw_addr_ff == `PAL_OFF_STATUS) begin
			wr_ok = 1'b1; // read-only, write ignored
		end else begin
			wr_ok = term_hit(aw_addr_ff);
		end
	end

	// write address and data captured independently, either order
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			aw_hold_ff <= 1'b0;
			aw_addr_ff <= '0;
			w_hold_ff  <= 1'b0;
			w_data_ff  <= '0;
			w_strb_ff  <= '0;
		end else begin
			if (AXI_REQ.awvalid && AXI_RSP.awready) begin
				aw_hold_ff <= 1'b1;
				aw_addr_ff <= AXI_REQ.awaddr;
			end else if (do_wr) begin
				aw_hold_ff <= 1'b0;
			end
			if (AXI_REQ.wvalid && AXI_RSP.wready) begin
				w_hold_ff <= 1'b1;
				w_data_ff <= AXI_REQ.wdata;
				w_strb_ff <= AXI_REQ.wstrb;
			end else if (do_wr) begin
				w_hold_ff <= 1'b0;
			end
		end
	end

	// write response
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= `PAL_RESP_OKAY;
		end else if (do_wr) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wr_ok ? `PAL_RESP_OKAY : `PAL_RESP_DECERR;
		end else if (AXI_REQ.bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// macrocell fuses; security only ever blows, heals only at reset
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			mode_ff <= `PAL_RST_MODE;
			pol_ff  <= `PAL_RST_POL;
			sec_ff  <= 1'b0;
		end else if (do_wr) begin
			if (aw_addr_ff == `PAL_OFF_MODE) begin
				mode_ff <= mode_mrg[`PAL_NUM_MC-1:0];
			end else if (aw_addr_ff == `PAL_OFF_POL) begin
				pol_ff <= pol_mrg[`PAL_NUM_MC-1:0];
			end else if (aw_addr_ff == `PAL_OFF_SEC) begin
				sec_ff <= sec_ff || (w_strb_ff[0] && w_data_ff[0]);
			end
		end
	end

	// product-term rows, two words each: low 32 columns, high 12
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			for (int t = 0; t < `PAL_NUM_PT; t++) begin
				fuse_ff[t] <= '0;
			end
		end else if (do_wr && term_hit(aw_addr_ff)) begin
			if (aw_addr_ff[2]) begin
				fuse_ff[term_idx(aw_addr_ff)][`PAL_NUM_COL-1:32] <=
					row_hi_mrg[`PAL_HI_W-1:0];
			end else begin
				fuse_ff[term_idx(aw_addr_ff)][31:0] <= row_lo_mrg;
			end
		end
	end

	// read decode; a blown security fuse shows every fuse as open
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		nxt_rresp = `PAL_RESP_OKAY;
		if (AXI_REQ.araddr == `PAL_OFF_MODE) begin
			nxt_rdata[`PAL_NUM_MC-1:0] = sec_ff ? '1 : mode_ff;
		end else if (AXI_REQ.araddr == `PAL_OFF_POL) begin
			nxt_rdata[`PAL_NUM_MC-1:0] = sec_ff ? '1 : pol_ff;
		end else if (AXI_REQ.araddr == `PAL_OFF_SEC) begin
			nxt_rdata[0] = sec_ff;
		end else if (AXI_REQ.araddr == `PAL_OFF_PRELOAD) begin
			nxt_rdata[`PAL_NUM_MC-1:0] = q_ff;
		end else if (AXI_REQ.araddr == `PAL_OFF_STATUS) begin
			nxt_rdata[`PAL_STAT_PIN_LSB +: `PAL_NUM_MC] = pin_s_ff;
			nxt_rdata[`PAL_STAT_OE_LSB +: `PAL_NUM_MC]  = IO_OE;
		end else if (term_hit(AXI_REQ.araddr)) begin
			if (sec_ff) begin
				nxt_rdata = AXI_REQ.araddr[2] ? 32'h0000_0FFF
					: 32'hFFFF_FFFF;
			end else if (AXI_REQ.araddr[2]) begin
				nxt_rdata[`PAL_HI_W-1:0] =
					fuse_ff[term_idx(AXI_REQ.araddr)][`PAL_NUM_COL-1:32];
			end else begin
				nxt_rdata = fuse_ff[term_idx(AXI_REQ.araddr)][31:0];
			end
		end else begin
			nxt_rresp = `PAL_RESP_DECERR;
		end
	end

	// read channel: one read in flight, answer the cycle after
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
			rresp_ff  <= `PAL_RESP_OKAY;
		end else if (AXI_REQ.arvalid && AXI_RSP.arready) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= nxt_rdata;
			rresp_ff  <= nxt_rresp;
		end else if (AXI_REQ.rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// bus outputs; readies refuse while a response is pending
	always_comb begin
		AXI_RSP.awready = !aw_hold_ff && !bvalid_ff;
		AXI_RSP.wready  = !w_hold_ff && !bvalid_ff;
		AXI_RSP.bvalid  = bvalid_ff;
		AXI_RSP.bresp   = bresp_ff;
		AXI_RSP.arready = !rvalid_ff;
		AXI_RSP.rvalid  = rvalid_ff;
		AXI_RSP.rdata   = rdata_ff;
		AXI_RSP.rresp   = rresp_ff;
	end

	// checks

	logic rd_fuse_ff; // last read taken hit a fuse location
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			rd_fuse_ff <= 1'b0;
		end else if (AXI_REQ.arvalid && AXI_RSP.arready) begin
			rd_fuse_ff <= (AXI_REQ.araddr == `PAL_OFF_MODE)
				|| (AXI_REQ.araddr == `PAL_OFF_POL)
				|| term_hit(AXI_REQ.araddr);
		end
	end

	chk_set_loads_ones: assert property (
		(set_pt && !pre_we && !clr_pt) ##1 !clr_pt |-> q_ff == '1)
		else $error("set term did not load ones");
	chk_reset_clears_all: assert property (
		clr_pt |-> (q_ff == '0) && (!$past(clr_pt) || $stable(q_ff)))
		else $error("reset term did not hold registers clear");
	chk_reg_pin_polarity: assert property (
		((IO_OUT ^ ~pol_ff) & ~mode_ff) == (q_ff & ~mode_ff))
		else $error("registered pin not register through polarity");
	chk_comb_pin_follows: assert property (
		((IO_OUT ^ ~pol_ff) & mode_ff) == (sum & mode_ff))
		else $error("combinational pin not following sum");
	chk_preload_value: assert property (
		pre_we && !clr_pt && w_strb_ff == 4'hF ##1 !clr_pt
		|-> q_ff == $past(w_data_ff[`PAL_NUM_MC-1:0], 1))
		else $error("preload value not loaded");
	chk_data_clocked_in: assert property (
		!pre_we && !set_pt && !clr_pt ##1 !clr_pt
		|-> q_ff == $past(sum, 1))
		else $error("register did not capture sum");
	chk_oe_own_term: assert property (
		IO_OE == pt[`PAL_PT_OE +: `PAL_NUM_MC])
		else $error("output enable not from its term");
	chk_security_hides: assert property (
		sec_ff && AXI_REQ.arvalid && AXI_RSP.arready
		&& (AXI_REQ.araddr == `PAL_OFF_POL)
		|=> rdata_ff[`PAL_NUM_MC-1:0] == '1 && rd_fuse_ff)
		else $error("fuse readout not hidden");
	chk_security_sticky: assert property (
		sec_ff |=> sec_ff)
		else $error("security fuse healed");
	chk_write_answered: assert property (
		do_wr |=> bvalid_ff ##1 1'b1)
		else $error("write not answered");

	cov_set_used:    cover property (set_pt ##1 q_ff == '1);
	cov_reset_used:  cover property (clr_pt && $past(q_ff) != '0);
	cov_preload:     cover property (pre_we);
	cov_comb_driven: cover property (|(mode_ff & IO_OE));
endmodule

// ### pal_board_model.sv
// board around the macrocell array: dedicated inputs and the ten i/o wires
// assumes the bench says what the board wants on every wire it owns
`include "pal_macrocell_regs.svh"
module pal_board_model (
	input  wire logic [`PAL_NUM_IN-1:0] din_drv,
	input  wire pal_pkg::pal_mc_t       pin_drv,
	input  wire pal_pkg::pal_mc_t       io_out,
	input  wire pal_pkg::pal_mc_t       io_oe,
	output logic      [`PAL_NUM_IN-1:0] din,
	output pal_pkg::pal_mc_t            io_in
);
	import pal_pkg::*;

	// dedicated inputs are plain board nets
	assign din = din_drv;

	// wire level: the device wins where it drives, the board elsewhere
	// no pull on these nets, so a released pin shows the board's value
	assign io_in = (io_oe & io_out) | (~io_oe & pin_drv);
endmodule

// ### pal_macrocell_array_tb.sv
// self-checking bench: axi4-lite tasks, fuse rows, pin stimulus
// assumes pal_pkg, the array and the board model are compiled first
`include "pal_macrocell_regs.svh"
module pal_macrocell_array_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import pal_pkg::*;

	logic         sys_clk;   // 100 MHz
	logic         nrst;      // active-low reset
	logic [11:0]  din_drv;   // board value on dedicated inputs
	pal_mc_t      pin_drv;   // board value on released i/o wires
	logic [11:0]  din;
	pal_mc_t      io_in;
	pal_mc_t      io_out;
	pal_mc_t      io_oe;
	pal_axi_req_t req;       // master side of the register port
	pal_axi_rsp_t rsp;
	int           error_cnt = 0;
	int           n_checks  = 0;
	int           cyc       = 0;
	int           base [10] = '{0, 8, 18, 30, 44, 60, 76, 90, 102, 112};
	logic [31:0]  rd;        // last read data
	logic [1:0]   rsp_code;  // last response code
	logic [11:0]  cv [4] = '{12'h004, 12'h006, 12'h001, 12'h000};
	logic [31:0]  ce [4] = '{32'h001, 32'h001, 32'h3FE, 32'h3FE};

	pal_macrocell_array u_pal_macrocell_array (
		.SYS_CLK (sys_clk),
		.NRST    (nrst),
		.DIN     (din),
		.IO_IN   (io_in),
		.IO_OUT  (io_out),
		.IO_OE   (io_oe),
		.AXI_REQ (req),
		.AXI_RSP (rsp)
	);

	pal_board_model u_pal_board_model (
		.din_drv (din_drv),
		.pin_drv (pin_drv),
		.io_out  (io_out),
		.io_oe   (io_oe),
		.din     (din),
		.io_in   (io_in)
	);

	// free-running clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// hang guard: the whole run needs well under 3000 cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			$display("timeout after %0d cycles", cyc);
			give_verdict();
		end
	end

	// compare and count
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one write; address and data released each at its own handshake
	task automatic axw(input logic [11:0] a, input logic [31:0] d);
		logic aw_p;
		logic w_p;
		@(posedge sys_clk);
		aw_p = 1'b1;
		w_p  = 1'b1;
		req.awaddr  <= a;
		req.wdata   <= d;
		req.awvalid <= 1'b1;
		req.wvalid  <= 1'b1;
		while (aw_p || w_p) begin
			@(posedge sys_clk);
			if (aw_p && rsp.awready) begin
				aw_p = 1'b0;
				req.awvalid <= 1'b0;
			end
			if (w_p && rsp.wready) begin
				w_p = 1'b0;
				req.wvalid <= 1'b0;
			end
		end
		// bready stays high, so the edge that sees bvalid ends it
		while (!rsp.bvalid) @(posedge sys_clk);
		rsp_code = rsp.bresp;
	endtask

	// one read; rready stays high throughout
	task automatic axr(input logic [11:0] a);
		@(posedge sys_clk);
		req.araddr  <= a;
		req.arvalid <= 1'b1;
		do @(posedge sys_clk); while (!rsp.arready);
		req.arvalid <= 1'b0;
		do @(posedge sys_clk); while (!rsp.rvalid);
		rd       = rsp.rdata;
		rsp_code = rsp.rresp;
	endtask

	// program one row so that it is a single column, or true if col < 0
	task automatic term(input int row, input int col);
		logic [43:0] m;
		m = '1;
		if (col >= 0) m[col] = 1'b0;
		axw(12'h400 + 12'(row * 8), m[31:0]);
		axw(12'h404 + 12'(row * 8), {20'h0, m[43:32]});
	endtask

	// new dedicated-input value, then room for sync and one clock
	task automatic drive(input logic [11:0] v);
		@(posedge sys_clk);
		din_drv <= v;
		repeat (5) @(posedge sys_clk);
	endtask

	// counts, verdict, end of run
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		nrst    = 1'b0;
		din_drv = 12'h000;
		pin_drv = 10'h000;
		req     = '0;
		req.wstrb  = 4'hF;
		req.bready = 1'b1;
		req.rready = 1'b1;
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		// reset state and an unmapped place
		chk("pins", 32'(io_out), 32'h3FF);
		chk("oe", 32'(io_oe), 32'h0);
		axr(`PAL_OFF_MODE);
		chk("mode", rd, 32'h0);
		axr(`PAL_OFF_POL);
		chk("pol", rd, 32'h0);
		// byte strobe: only lane 1 of the mode word lands
		req.wstrb <= 4'h2;
		axw(`PAL_OFF_MODE, 32'h0000_0301);
		req.wstrb <= 4'hF;
		axr(`PAL_OFF_MODE);
		chk("mode strobe", rd, 32'h300);
		axw(`PAL_OFF_MODE, 32'h0);
		axr(12'h020);
		chk("unmapped", 32'(rsp_code), 32'(`PAL_RESP_DECERR));
		$display("test reset done");
		// every cell holds its own register through one feedback term
		for (int n = 0; n < 10; n++) term(base[n], 12 + n);
		axw(`PAL_OFF_POL, 32'h3FF);
		chk("pins high", 32'(io_out), 32'h0);
		axw(`PAL_OFF_PRELOAD, 32'h2A5);
		repeat (3) @(posedge sys_clk);
		axr(`PAL_OFF_PRELOAD);
		chk("preload", rd, 32'h2A5);
		chk("pins q", 32'(io_out), 32'h2A5);
		axw(`PAL_OFF_POL, 32'h0);
		chk("pins inv", 32'(io_out), 32'h15A);
		axw(`PAL_OFF_POL, 32'h3FF);
		$display("test preload done");
		// shared set term on dedicated input 0
		term(130, 0);
		drive(12'h001);
		chk("set", 32'(io_out), 32'h3FF);
		drive(12'h000);
		chk("set hold", 32'(io_out), 32'h3FF);
		$display("test set done");
		// shared clear term on input 1: seen before the next clock
		term(131, 1);
		axw(`PAL_OFF_PRELOAD, 32'h2A5);
		@(posedge sys_clk);
		din_drv <= 12'h002;
		repeat (3) @(posedge sys_clk);
		chk("clear", 32'(io_out), 32'h0);
		drive(12'h003);
		chk("clear over set", 32'(io_out), 32'h0);
		$display("test clear done");
		// cell 0 combinational on input 2, untouched by set and clear
		term(base[0], 2);
		axw(`PAL_OFF_MODE, 32'h1);
		for (int i = 0; i < 4; i++) begin
			drive(cv[i]);
			chk("comb", 32'(io_out), ce[i]);
		end
		$display("test combinational done");
		// enable of cell 3 always true, the other wires are inputs
		term(123, -1);
		chk("oe one", 32'(io_oe), 32'h008);
		@(posedge sys_clk);
		pin_drv <= 10'h137;
		repeat (4) @(posedge sys_clk);
		axw(`PAL_OFF_STATUS, 32'h0);
		chk("status wr", 32'(rsp_code), 32'(`PAL_RESP_OKAY));
		axr(`PAL_OFF_STATUS);
		chk("status", rd, 32'h0008_013F);
		$display("test pins done");
		// security fuse hides the rest
		axw(`PAL_OFF_SEC, 32'h1);
		axr(`PAL_OFF_MODE);
		chk("sec mode", rd, 32'h3FF);
		axr(`PAL_OFF_POL);
		chk("sec pol", rd, 32'h3FF);
		axr(12'h400);
		chk("sec lo", rd, 32'hFFFF_FFFF);
		axr(12'h404);
		chk("sec hi", rd, 32'h0000_0FFF);
		$display("test security done");
		give_verdict();
	end
endmodule
